// *** hdl/lcs_pkg.sv ***
/*
 * Shared constants and types for the ladder coil scan engine.
 * Assumes one 10 MHz clock and a program store loaded while stopped.
 */
// Contract
// (RULE1) in run mode the whole diagram is evaluated again and again, one pass per scan
// (RULE2) the diagram store holds exactly 256 rungs, each with contacts and one coil
// (RULE3) four series contact positions per rung; leftmost is fed with logic true
// (RULE4) make contact passes its operand, break contact passes the inverse
// (RULE5) coils change from rung results only in run mode; each is on or off
// (RULE6) new coil state comes from its rung power flow and its coil function
// (RULE7) seven coil functions, chosen per coil by an encoding
// (RULE8) contactor coil equals rung power flow in the same scan, no memory
// (RULE9) impulse coil toggles on each 0-to-1 rung result, else holds
// (RULE10) function blocks are stepped with the diagram and refreshed each scan
// (RULE11) set and reset latch; same scan, the higher-numbered rung wins
// (RULE12) negated contactor coil equals inverse of rung power flow
// (RULE13) edge pulse coils are 1 for exactly one scan after their edge
// (RULE14) stop or power loss clears non-retentive coils; retentive ones keep state
// (RULE15) rungs run in ascending order; earlier coil writes seen by later rungs
// (RULE16) edge and impulse detection use a per-coil result stored from last scan
package lcs_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int NRUNG    = 256;
   localparam int NCOIL    = 256;
   localparam int NCONTACT = 4;
   localparam int IDXW     = 8;
   localparam int SELW     = 9;
   localparam int SEL_COIL = 8;   // operand select bit: 1 = coil, 0 = input pin or fb result

   // ***************************************************************
   // first and last rung index
   // ***************************************************************
   localparam logic [IDXW-1:0] RUNG_FIRST = 8'h00;
   localparam logic [IDXW-1:0] RUNG_LAST  = 8'hFF;

   // ***************************************************************
   // encodings
   // ***************************************************************
   typedef enum logic [1:0] {
      LCS_CT_WIRE,
      LCS_CT_MAKE,
      LCS_CT_BREAK,
      LCS_CT_OPEN
   } lcs_contact_kind_t;

   typedef enum logic [2:0] {
      LCS_CF_NONE,
      LCS_CF_CONTACTOR,
      LCS_CF_IMPULSE,
      LCS_CF_SET,
      LCS_CF_RESET,
      LCS_CF_NEGATED,
      LCS_CF_RISE,
      LCS_CF_FALL
   } lcs_coil_func_t;

   typedef struct packed {
      lcs_contact_kind_t kind;
      logic [SELW-1:0]   sel;
   } lcs_contact_t;

   typedef struct packed {
      lcs_contact_t [NCONTACT-1:0] contact;   // contact[0] is leftmost
      lcs_coil_func_t              func;
      logic [IDXW-1:0]             coil;
   } lcs_rung_t;

endpackage

// *** hdl/lcs_scan.sv ***
/*
 * Ladder coil scan engine: stores 256 rungs and evaluates them
 * cyclically while in run mode, one rung per clock.
 * Assumes pins, run and power-fail arrive asynchronously, and that
 * the program port and function-block results come from logic on clk.
 */
`timescale 1ns/1ps

module lcs_scan #(
   parameter int NIN = 16,
   parameter int NFB = 16
) (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   run_req,
   input  wire logic                   power_fail,
   input  wire logic [NIN-1:0]         pin_in,
   input  wire logic [lcs_pkg::NCOIL-1:0] retain_mask,
   input  wire logic                   prog_we,
   input  wire logic [lcs_pkg::IDXW-1:0] prog_addr,
   input  wire lcs_pkg::lcs_rung_t     prog_data,
   input  wire logic [NFB-1:0]         fb_result,
   output logic                        prog_ack,
   output logic                        running,
   output logic                        scan_start,
   output logic                        scan_done,
   output logic [lcs_pkg::IDXW-1:0]    rung_index,
   output logic [lcs_pkg::NCOIL-1:0]   coil_out
);

   // ***************************************************************
   // reset release and input synchronisers
   // ***************************************************************
   logic                       rst_q1;
   logic                       rst_n;
   logic                       run_q1;
   logic                       run_s;
   logic                       pf_q1;
   logic                       pf_s;
   logic [NIN-1:0]             pin_q1;
   logic [NIN-1:0]             pin_s;
   logic [lcs_pkg::NCOIL-1:0]  ret_q1;
   logic [lcs_pkg::NCOIL-1:0]  ret_s;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q1 <= 1'b0;
         run_s  <= 1'b0;
         pf_q1  <= 1'b0;
         pf_s   <= 1'b0;
         pin_q1 <= '0;
         pin_s  <= '0;
         ret_q1 <= '0;
         ret_s  <= '0;
      end else begin
         run_q1 <= run_req;
         run_s  <= run_q1;
         pf_q1  <= power_fail;
         pf_s   <= pf_q1;
         pin_q1 <= pin_in;
         pin_s  <= pin_q1;
         ret_q1 <= retain_mask;
         ret_s  <= ret_q1;
      end
   end

   // ***************************************************************
   // program store
   // ***************************************************************
   lcs_pkg::lcs_rung_t prog_mem [lcs_pkg::NRUNG];   // RULE2

   // editing only while stopped, so a scan never sees a half-new diagram
   always_ff @(posedge clk) begin
      if (prog_we && !running) begin
         prog_mem[prog_addr] <= prog_data;   // RULE2
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_ack <= 1'b0;
      end else begin
         prog_ack <= prog_we && !running;
      end
   end

   // ***************************************************************
   // scan sequencer
   // ***************************************************************
   typedef enum logic [1:0] {
      LCS_ST_STOP,
      LCS_ST_LATCH,
      LCS_ST_RUNG,
      LCS_ST_END
   } lcs_state_t;

   lcs_state_t                 state;
   logic [lcs_pkg::IDXW-1:0]   rung;
   logic                       stop_now;

   assign stop_now = !run_s || pf_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= LCS_ST_STOP;
         rung  <= lcs_pkg::RUNG_FIRST;
      end else if (stop_now) begin
         state <= LCS_ST_STOP;
         rung  <= lcs_pkg::RUNG_FIRST;
      end else begin
         unique case (state)
            LCS_ST_STOP: begin
               state <= LCS_ST_LATCH;
            end
            LCS_ST_LATCH: begin
               state <= LCS_ST_RUNG;
               rung  <= lcs_pkg::RUNG_FIRST;
            end
            LCS_ST_RUNG: begin
               if (rung == lcs_pkg::RUNG_LAST) begin
                  state <= LCS_ST_END;
               end else begin
                  rung <= rung + 8'h01;   // RULE15
               end
            end
            LCS_ST_END: begin
               state <= LCS_ST_LATCH;   // RULE1
            end
         endcase
      end
   end

   assign running    = (state != LCS_ST_STOP);
   assign scan_start = (state == LCS_ST_LATCH);
   assign scan_done  = (state == LCS_ST_END);
   assign rung_index = rung;

   // ***************************************************************
   // input images, taken once per scan
   // ***************************************************************
   logic [lcs_pkg::NCOIL-1:0]  in_img;
   logic [lcs_pkg::NCOIL-1:0]  fb_img;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_img <= '0;
         fb_img <= '0;
      end else if (state == LCS_ST_LATCH) begin
         in_img <= lcs_pkg::NCOIL'(pin_s);
         fb_img <= lcs_pkg::NCOIL'(fb_result);   // RULE10
      end
   end

   // ***************************************************************
   // rung evaluation
   // ***************************************************************
   // select bit 8 picks a coil; otherwise low half pins, high half fb results
   function automatic logic operand(input logic [lcs_pkg::SELW-1:0] sel,
                                    input logic [lcs_pkg::NCOIL-1:0] coils,
                                    input logic [lcs_pkg::NCOIL-1:0] ins,
                                    input logic [lcs_pkg::NCOIL-1:0] fbs);
      logic [lcs_pkg::IDXW-1:0] idx;
      idx = sel[lcs_pkg::IDXW-1:0];
      if (sel[lcs_pkg::SEL_COIL]) begin
         operand = coils[idx];
      end else if (idx[7]) begin
         operand = fbs[{1'b0, idx[6:0]}];
      end else begin
         operand = ins[idx];
      end
   endfunction

   lcs_pkg::lcs_rung_t         cur;
   logic                       power;
   logic                       bit_val;

   assign cur = prog_mem[rung];

   always_comb begin
      power   = 1'b1;   // RULE3
      bit_val = 1'b0;
      for (int i = 0; i < lcs_pkg::NCONTACT; i++) begin
         bit_val = operand(cur.contact[i].sel, coil_out, in_img, fb_img);
         unique case (cur.contact[i].kind)
            lcs_pkg::LCS_CT_WIRE:  power = power;
            lcs_pkg::LCS_CT_MAKE:  power = power & bit_val;    // RULE4
            lcs_pkg::LCS_CT_BREAK: power = power & ~bit_val;   // RULE4
            lcs_pkg::LCS_CT_OPEN:  power = 1'b0;
         endcase
      end
   end

   // ***************************************************************
   // coil update
   // ***************************************************************
   logic [lcs_pkg::NCOIL-1:0]  prev_res;
   logic                       old_res;
   logic                       old_coil;
   logic                       next_coil;
   logic                       eval;

   assign eval     = (state == LCS_ST_RUNG) && (cur.func != lcs_pkg::LCS_CF_NONE);
   assign old_res  = prev_res[cur.coil];
   assign old_coil = coil_out[cur.coil];

   always_comb begin
      unique case (cur.func)   // RULE6 RULE7
         lcs_pkg::LCS_CF_NONE:      next_coil = old_coil;
         lcs_pkg::LCS_CF_CONTACTOR: next_coil = power;                          // RULE8
         lcs_pkg::LCS_CF_IMPULSE:   next_coil = old_coil ^ (power & ~old_res);  // RULE9
         lcs_pkg::LCS_CF_SET:       next_coil = old_coil | power;               // RULE11
         lcs_pkg::LCS_CF_RESET:     next_coil = old_coil & ~power;              // RULE11
         lcs_pkg::LCS_CF_NEGATED:   next_coil = ~power;                         // RULE12
         lcs_pkg::LCS_CF_RISE:      next_coil = power & ~old_res;               // RULE13
         lcs_pkg::LCS_CF_FALL:      next_coil = ~power & old_res;               // RULE13
      endcase
   end

   // later rungs overwrite earlier ones, so the higher rung wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coil_out <= '0;
      end else if (stop_now && running) begin
         coil_out <= coil_out & ret_s;   // RULE14
      end else if (pf_s) begin
         coil_out <= coil_out & ret_s;   // RULE14
      end else if (eval) begin
         coil_out[cur.coil] <= next_coil;   // RULE5 RULE11 RULE15
      end
   end

   // stored rung result per coil, for the edge functions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_res <= '0;
      end else if (eval) begin
         prev_res[cur.coil] <= power;   // RULE16
      end
   end

endmodule

// *** testbench/lcs_scan_properties.sv ***
/*
 * Checker of scan timing, program port and coil clearing of lcs_scan.
 * Assumes retain_mask is held steady by its driver.
 */
`timescale 1ns/1ps

module lcs_scan_checker (
   input wire logic                      clk,
   input wire logic                      resetn,
   input wire logic                      power_fail,
   input wire logic                      prog_we,
   input wire logic                      prog_ack,
   input wire logic                      running,
   input wire logic                      scan_start,
   input wire logic                      scan_done,
   input wire logic [lcs_pkg::IDXW-1:0]  rung_index,
   input wire logic [lcs_pkg::NCOIL-1:0] retain_mask,
   input wire logic [lcs_pkg::NCOIL-1:0] coil_out
);
   // ***************************************************************
   // helper logic
   // ***************************************************************
   // cycles since scan_start within one unbroken run; 0 once stopped
   logic [8:0] scan_age;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scan_age <= 9'h000;
      end else if (scan_start) begin
         scan_age <= 9'h001;
      end else if (!running || (scan_age == 9'h000)) begin
         scan_age <= 9'h000;
      end else begin
         scan_age <= scan_age + 9'h001;
      end
   end

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   write_ack_a: assert property (prog_we && !running |=> prog_ack)
      else $error("write while stopped not acknowledged");
   write_refused_a: assert property (prog_we && running |=> !prog_ack)
      else $error("write while running acknowledged");
   ack_cause_a: assert property (prog_ack |-> $past(prog_we) && !$past(running))
      else $error("acknowledge without accepted write");
   scan_period_a: assert property (scan_done |-> (scan_age == 9'h101))
      else $error("scan length wrong");
   scan_end_a: assert property ((scan_age == 9'h101) && running |-> scan_done)
      else $error("unbroken scan did not end");
   scan_repeat_a: assert property (scan_done |=> (scan_start || !running))
      else $error("scan not restarted");
   first_rung_a: assert property (scan_start |=> (rung_index == 8'h00))
      else $error("scan does not begin at rung zero");
   last_rung_a: assert property (scan_done |-> ($past(rung_index) == 8'hFF))
      else $error("scan ends before last rung");
   stop_frozen_a: assert property (!running |=> ((coil_out & ~$past(coil_out)) == '0))
      else $error("coil switched on while stopped");
   stop_clear_a: assert property ($fell(running) |-> ((coil_out & ~retain_mask) == '0))
      else $error("non-retentive coil kept at stop");
   power_loss_a: assert property (power_fail [*4] |-> !running && ((coil_out & ~retain_mask) == '0))
      else $error("power loss did not stop and clear");
endmodule

bind lcs_scan lcs_scan_checker chk_u (
   .clk         (clk),
   .resetn      (resetn),
   .power_fail  (power_fail),
   .prog_we     (prog_we),
   .prog_ack    (prog_ack),
   .running     (running),
   .scan_start  (scan_start),
   .scan_done   (scan_done),
   .rung_index  (rung_index),
   .retain_mask (retain_mask),
   .coil_out    (coil_out)
);

// *** testbench/lcs_scan_tb.sv ***
/*
 * Self-checking bench for lcs_scan: programs all 256 rungs, twelve with coils, runs scans
 * with changing pins and checks coils, then forces a power loss and a stop.
 * Assumes NIN and NFB of 16 and coil 0 alone retentive.
 */
`timescale 1ns/1ps

module lcs_scan_tb;
   logic               clk = 1'b0;
   logic               resetn = 1'b0;
   logic               run_req = 1'b0;
   logic               power_fail = 1'b0;
   logic               prog_we = 1'b0;
   logic [7:0]         prog_addr = 8'h00;
   lcs_pkg::lcs_rung_t prog_data = '0;
   logic [15:0]        pin_in = 16'h0000;
   logic [15:0]        fb_result = 16'h0000;
   logic [255:0]       retain_mask = 256'h1;
   logic               prog_ack, running, scan_start, scan_done;
   logic [7:0]         rung_index;
   logic [255:0]       coil_out;
   int                 fail_count = 0;
   int                 n_checks = 0;
   int                 cycles = 0;

   lcs_scan #(.NIN(16), .NFB(16)) dut_u (
      .clk(clk), .resetn(resetn), .run_req(run_req), .power_fail(power_fail),
      .pin_in(pin_in), .retain_mask(retain_mask), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_data(prog_data), .fb_result(fb_result),
      .prog_ack(prog_ack), .running(running), .scan_start(scan_start),
      .scan_done(scan_done), .rung_index(rung_index), .coil_out(coil_out));

   initial begin
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         fail_count++;
         results();
      end
   end

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // contacts are {kind, operand}; one rung per call
   task automatic wr(input logic [7:0] a, input logic [10:0] c1, input logic [10:0] c0,
                     input logic [2:0] f, input logic [7:0] c, input logic ack);
      lcs_pkg::lcs_rung_t w;
      w = '0;
      w.contact[1] = c1;
      w.contact[0] = c0;
      w.func = lcs_pkg::lcs_coil_func_t'(f);
      w.coil = c;
      prog_data = w;
      prog_addr = a;
      prog_we = 1'b1;
      @(negedge clk);
      chk(256'(prog_ack), 256'(ack));
   endtask

   task automatic wait_done();
      @(negedge clk);
      while (scan_done !== 1'b1) @(negedge clk);
   endtask

   // second scan after the change is the first to see the new pins
   task automatic step(input logic [15:0] p, input logic [15:0] fb, input logic [11:0] e);
      pin_in = p;
      fb_result = fb;
      wait_done();
      wait_done();
      chk(coil_out, 256'(e));
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset();
      repeat (3) @(negedge clk);
      chk(256'({running, scan_start, scan_done, prog_ack, rung_index}), 256'h0);
      chk(coil_out, 256'h0);
      $display("reset test done");
   endtask

   task automatic t_prog();
      wr(8'h00, 11'h000, 11'h200, 3'h1, 8'h00, 1'b1);
      wr(8'h01, 11'h000, 11'h200, 3'h5, 8'h01, 1'b1);
      wr(8'h02, 11'h000, 11'h200, 3'h2, 8'h02, 1'b1);
      wr(8'h03, 11'h000, 11'h201, 3'h3, 8'h03, 1'b1);
      wr(8'h04, 11'h000, 11'h202, 3'h4, 8'h03, 1'b1);
      wr(8'h05, 11'h000, 11'h200, 3'h6, 8'h05, 1'b1);
      wr(8'h06, 11'h000, 11'h200, 3'h7, 8'h06, 1'b1);
      wr(8'h07, 11'h203, 11'h300, 3'h1, 8'h07, 1'b1);
      wr(8'h08, 11'h000, 11'h280, 3'h1, 8'h08, 1'b1);
      wr(8'h09, 11'h000, 11'h400, 3'h1, 8'h09, 1'b1);
      wr(8'h0A, 11'h000, 11'h600, 3'h1, 8'h0A, 1'b1);
      wr(8'h0B, 11'h000, 11'h000, 3'h1, 8'h0B, 1'b1);
      for (int r = 12; r < 256; r++) begin
         wr(8'(r), 11'h000, 11'h000, 3'h0, 8'(r), 1'b1);
      end
      prog_we = 1'b0;
      $display("program test done");
   endtask

   task automatic t_run();
      run_req = 1'b1;
      repeat (2) @(negedge clk);
      chk(256'(running), 256'h0);
      @(negedge clk);
      chk(256'({running, scan_start}), 256'h3);
      @(negedge clk);
      chk(256'(rung_index), 256'h0);
      repeat (256) @(negedge clk);
      chk(256'(scan_done), 256'h1);
      chk(coil_out, 256'hA02);
      @(negedge clk);
      chk(256'(scan_start), 256'h1);
      $display("first scan test done");
   endtask

   task automatic t_coils();
      step(16'h000B, 16'h0001, 12'h9AD);
      step(16'h000B, 16'h0001, 12'h98D);
      wr(8'h00, 11'h000, 11'h000, 3'h0, 8'h00, 1'b0);
      prog_we = 1'b0;
      step(16'h0004, 16'h0000, 12'hA46);
      step(16'h0007, 16'h0000, 12'h821);
      $display("coil function test done");
   endtask

   task automatic t_power();
      power_fail = 1'b1;
      repeat (4) @(negedge clk);
      chk(256'(running), 256'h0);
      chk(coil_out, 256'h1);
      run_req = 1'b0;
      power_fail = 1'b0;
      repeat (4) @(negedge clk);
      chk(coil_out, 256'h1);
      $display("power loss test done");
   endtask

   // stop from run mode clears every coil but the retentive coil 0
   task automatic t_stop();
      run_req = 1'b1;
      step(16'h0001, 16'h0000, 12'h801);
      run_req = 1'b0;
      repeat (4) @(negedge clk);
      chk(256'(running), 256'h0);
      chk(coil_out, 256'h1);
      $display("stop test done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_prog();
      t_run();
      t_coils();
      t_power();
      t_stop();
      results();
   end
endmodule
